// ===== dcs_defines.svh
// Register map, field positions, codes and reset values of the channel status/control block
// Functional notes
// - Size code 00 gives 32-bit, 01 16-bit, 10 8-bit; 11 reserved.
// - Size applies only in external-request or memory-to-memory mode, else 32-bit.
// - Six-bit read field shows the channel state with one-hot style codes.
// - Ten-bit read field shows the byte offset within the current descriptor.
// - Writing one clears a pending flag; zero leaves it unchanged.
// - Interrupt raised when a pending flag and its enable, bits 23..20, are set.
// - Normal-done pending set on normal close if its enable or descriptor done-irq set.
// - Descriptor closes normally at zero remaining bytes or, in external-request mode, on peripheral completion.
// - Bad descriptor or data pointer sets error pending and halts without advancing.
// - After error pending clears, the same descriptor resumes where it stopped.
// - With abort_request set, the channel abandons the descriptor and moves to the next.
// - Descriptor with wrong owner bit sets buffer-not-ready pending and halts.
// - After buffer-not-ready pending clears, the same descriptor is fetched again.
// - Detecting abort_request sets abort pending; the channel halts until it clears.
// - Clearing abort pending advances; abort_request still set aborts the next too.
// - Status shows descriptor wrap, done-irq, last, full and 15-bit remaining count.
// - In external-request mode, peripheral transfer_end_n closes the buffer as a normal close and reports bytes moved.
`ifndef DCS_DEFINES_SVH
`define DCS_DEFINES_SVH

`define DCS_ADDR_CTRL 8'h00
`define DCS_ADDR_STAT 8'h04

`define DCS_CTRL_ENABLE 31
`define DCS_CTRL_ABORT 30
`define DCS_CTRL_MODE_HI 19
`define DCS_CTRL_MODE_LO 18
`define DCS_CTRL_SIZE_HI 17
`define DCS_CTRL_SIZE_LO 16
`define DCS_CTRL_STATE_HI 15
`define DCS_CTRL_STATE_LO 10
`define DCS_CTRL_INDEX_HI 9
`define DCS_CTRL_INDEX_LO 0

`define DCS_STAT_PEND_HI 31
`define DCS_STAT_PEND_LO 28
`define DCS_STAT_EN_HI 23
`define DCS_STAT_EN_LO 20
`define DCS_STAT_WRAP 19
`define DCS_STAT_DONE_IRQ 18
`define DCS_STAT_LAST 17
`define DCS_STAT_FULL 16
`define DCS_STAT_BYTES_REMAINING_HI 14
`define DCS_STAT_BYTES_REMAINING_LO 0

// Flag order inside the four-bit pending and enable groups
`define DCS_F_NORMAL 3
`define DCS_F_ERROR 2
`define DCS_F_NOTRDY 1
`define DCS_F_ABORT 0

`define DCS_SIZE_32 2'h0
`define DCS_SIZE_16 2'h1
`define DCS_SIZE_8 2'h2

`define DCS_MODE_INT 2'h0
`define DCS_MODE_EXT 2'h1
`define DCS_MODE_M2M 2'h2

`define DCS_CODE_IDLE 6'h00
`define DCS_CODE_LOAD_SRC 6'h01
`define DCS_CODE_LOAD_DST 6'h04
`define DCS_CODE_OP1 6'h08
`define DCS_CODE_OP2 6'h10
`define DCS_CODE_UPDATE 6'h20

`define DCS_RST_CTRL 32'h0000_0000
`define DCS_RST_EN 4'h0

`endif

// ===== dcs_pkg.sv
// Types shared by the channel status/control block
package dcs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_LOAD_DST,
    ST_OP1,
    ST_OP2,
    ST_UPDATE,
    ST_HALT
  } dcs_state_t;

  typedef enum logic [1:0] {
    HALT_ERROR,
    HALT_NOTRDY,
    HALT_ABORT
  } dcs_halt_t;

  typedef struct packed {
    logic owner_ok;
    logic wrap;
    logic done_irq;
    logic last;
    logic full;
    logic [14:0] bytes_remaining;
  } dcs_desc_t;

  typedef struct packed {
    logic enable;
    logic abort_request;
    logic [1:0] mode;
    logic [1:0] size;
  } dcs_ctrl_t;

endpackage

// ===== dcs_sticky_flag.sv
// One pending flag: hardware sets, software clears by writing one
`timescale 1ns/1ns
module dcs_sticky_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set,
  input wire logic clr,
  output logic q
);

  // A set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else begin
      q <= set | (q & ~clr);
    end
  end

endmodule

// ===== dcs_ahb_slave.sv
// AHB-Lite slave front end with zero wait states for the two channel registers
`timescale 1ns/1ns
`include "dcs_defines.svh"
module dcs_ahb_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] ctrl_val,
  input wire logic [31:0] stat_val,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic wr_ctrl,
  output logic wr_stat,
  output logic [31:0] wdata
);

  logic wr_q;
  logic [7:0] addr_q;
  logic take;

  assign take = hsel & hready & htrans[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_q <= take & hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // Read data sampled at the address edge; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (take & ~hwrite) begin
      if (haddr[7:0] == `DCS_ADDR_CTRL) begin
        hrdata <= ctrl_val;
      end else if (haddr[7:0] == `DCS_ADDR_STAT) begin
        hrdata <= stat_val;
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Writes land at the end of the data phase; unmapped writes are dropped
  assign wr_ctrl = wr_q & (addr_q == `DCS_ADDR_CTRL);
  assign wr_stat = wr_q & (addr_q == `DCS_ADDR_STAT);
  assign wdata = hwdata;

endmodule

// ===== dcs_channel.sv
// DMA channel status and control: descriptor sequencing, halts and pending flags
`timescale 1ns/1ns
`include "dcs_defines.svh"
module dcs_channel (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic desc_req,
  input wire logic desc_ack,
  input wire logic desc_bad_ptr,
  input wire dcs_pkg::dcs_desc_t desc_in,
  output logic desc_next,
  output logic xfer_req,
  output logic xfer_second,
  output logic [1:0] xfer_size,
  input wire logic xfer_ack,
  input wire logic xfer_err,
  input wire logic transfer_end_n,
  output logic wb_req,
  output logic [14:0] wb_len,
  input wire logic wb_ack,
  output logic irq
);

  dcs_pkg::dcs_state_t state_q, state_d;
  dcs_pkg::dcs_halt_t halt_q, halt_d;
  dcs_pkg::dcs_ctrl_t ctrl_q;
  dcs_pkg::dcs_desc_t desc_q;
  logic [3:0] en_q;
  logic [3:0] pend;
  logic [3:0] ev;
  logic [9:0] index_q;
  logic [14:0] bytes_remaining_q;
  logic loaded_q;
  logic adv, fetch_go, op_go, op2_go, wb_go, count, close_periph;
  logic wr_ctrl, wr_stat;
  logic [31:0] wdata, ctrl_val, stat_val;
  logic [5:0] state_code;
  logic [1:0] eff_size;
  logic [14:0] op_bytes;
  logic te_s1_q, te_s2_q, te_s3_q, te_low_q;

  dcs_ahb_slave u_bus (
    .clk(clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hwdata(hwdata),
    .ctrl_val(ctrl_val),
    .stat_val(stat_val),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr_ctrl(wr_ctrl),
    .wr_stat(wr_stat),
    .wdata(wdata)
  );

  // Control and enable registers written by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      en_q <= `DCS_RST_EN;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.enable <= wdata[`DCS_CTRL_ENABLE];
        ctrl_q.abort_request <= wdata[`DCS_CTRL_ABORT];
        ctrl_q.mode <= wdata[`DCS_CTRL_MODE_HI:`DCS_CTRL_MODE_LO];
        ctrl_q.size <= wdata[`DCS_CTRL_SIZE_HI:`DCS_CTRL_SIZE_LO];
      end
      if (wr_stat) begin
        en_q <= wdata[`DCS_STAT_EN_HI:`DCS_STAT_EN_LO];
      end
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_flag
    dcs_sticky_flag u_flag (
      .clk(clk),
      .rst_n(rst_n),
      .set(ev[i]),
      .clr(wr_stat & wdata[`DCS_STAT_PEND_LO + i]),
      .q(pend[i])
    );
  end

  always_comb begin
    case (state_q)
      dcs_pkg::ST_FETCH: state_code = `DCS_CODE_LOAD_SRC;
      dcs_pkg::ST_LOAD_DST: state_code = `DCS_CODE_LOAD_DST;
      dcs_pkg::ST_OP1: state_code = `DCS_CODE_OP1;
      dcs_pkg::ST_OP2: state_code = `DCS_CODE_OP2;
      dcs_pkg::ST_UPDATE: state_code = `DCS_CODE_UPDATE;
      default: state_code = `DCS_CODE_IDLE;
    endcase
  end

  assign ctrl_val = {ctrl_q.enable, ctrl_q.abort_request, 10'h000, ctrl_q.mode, ctrl_q.size,
                     state_code, index_q};
  assign stat_val = {pend, 4'h0, en_q, desc_q.wrap, desc_q.done_irq, desc_q.last,
                     desc_q.full, 1'b0, bytes_remaining_q};

  // Size field matters only for external request and memory-to-memory
  assign eff_size = (ctrl_q.mode == `DCS_MODE_EXT || ctrl_q.mode == `DCS_MODE_M2M) ?
                    ctrl_q.size : `DCS_SIZE_32;

  always_comb begin
    case (eff_size)
      `DCS_SIZE_16: op_bytes = 15'h0002;
      `DCS_SIZE_8: op_bytes = 15'h0001;
      default: op_bytes = 15'h0004; // Reserved code falls back to a full word
    endcase
  end

  // Peripheral end strobe from a pin: three stages, accepted once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      te_s1_q <= 1'b1;
      te_s2_q <= 1'b1;
      te_s3_q <= 1'b1;
      te_low_q <= 1'b0;
    end else begin
      te_s1_q <= transfer_end_n;
      te_s2_q <= te_s1_q;
      te_s3_q <= te_s2_q;
      if (te_s2_q == te_s3_q) begin
        te_low_q <= ~te_s3_q;
      end
    end
  end

  always_comb begin
    state_d = state_q;
    halt_d = halt_q;
    ev = 4'h0;
    adv = 1'b0;
    fetch_go = 1'b0;
    op_go = 1'b0;
    op2_go = 1'b0;
    wb_go = 1'b0;
    count = 1'b0;
    close_periph = 1'b0;
    case (state_q)
      dcs_pkg::ST_IDLE: begin
        if (ctrl_q.enable && ctrl_q.abort_request) begin
          ev[`DCS_F_ABORT] = 1'b1;
          halt_d = dcs_pkg::HALT_ABORT;
          state_d = dcs_pkg::ST_HALT;
        end else if (ctrl_q.enable) begin
          fetch_go = 1'b1;
          state_d = dcs_pkg::ST_FETCH;
        end
      end
      dcs_pkg::ST_FETCH: begin
        if (desc_ack && desc_bad_ptr) begin
          ev[`DCS_F_ERROR] = 1'b1;
          halt_d = dcs_pkg::HALT_ERROR;
          state_d = dcs_pkg::ST_HALT;
        end else if (desc_ack && !desc_in.owner_ok) begin
          ev[`DCS_F_NOTRDY] = 1'b1;
          halt_d = dcs_pkg::HALT_NOTRDY;
          state_d = dcs_pkg::ST_HALT;
        end else if (desc_ack) begin
          state_d = dcs_pkg::ST_LOAD_DST;
        end
      end
      dcs_pkg::ST_LOAD_DST: begin
        if (ctrl_q.abort_request) begin
          ev[`DCS_F_ABORT] = 1'b1;
          halt_d = dcs_pkg::HALT_ABORT;
          state_d = dcs_pkg::ST_HALT;
        end else if (bytes_remaining_q == 15'h0000 || (te_low_q && ctrl_q.mode == `DCS_MODE_EXT)) begin
          close_periph = (bytes_remaining_q != 15'h0000);
          wb_go = 1'b1;
          state_d = dcs_pkg::ST_UPDATE;
        end else begin
          op_go = 1'b1;
          state_d = dcs_pkg::ST_OP1;
        end
      end
      dcs_pkg::ST_OP1: begin
        if (xfer_ack && xfer_err) begin
          ev[`DCS_F_ERROR] = 1'b1;
          halt_d = dcs_pkg::HALT_ERROR;
          state_d = dcs_pkg::ST_HALT;
        end else if (xfer_ack && ctrl_q.mode == `DCS_MODE_M2M) begin
          op2_go = 1'b1;
          state_d = dcs_pkg::ST_OP2;
        end else if (xfer_ack) begin
          count = 1'b1;
          state_d = dcs_pkg::ST_LOAD_DST;
        end
      end
      dcs_pkg::ST_OP2: begin
        if (xfer_ack && xfer_err) begin
          ev[`DCS_F_ERROR] = 1'b1;
          halt_d = dcs_pkg::HALT_ERROR;
          state_d = dcs_pkg::ST_HALT;
        end else if (xfer_ack) begin
          count = 1'b1;
          state_d = dcs_pkg::ST_LOAD_DST;
        end
      end
      dcs_pkg::ST_UPDATE: begin
        if (wb_ack) begin
          ev[`DCS_F_NORMAL] = en_q[`DCS_F_NORMAL] | desc_q.done_irq;
          adv = 1'b1;
          state_d = dcs_pkg::ST_IDLE;
        end
      end
      dcs_pkg::ST_HALT: begin
        case (halt_q)
          dcs_pkg::HALT_ERROR: begin
            if (!pend[`DCS_F_ERROR]) begin
              fetch_go = 1'b1;
              state_d = dcs_pkg::ST_FETCH;
            end
          end
          dcs_pkg::HALT_NOTRDY: begin
            if (!pend[`DCS_F_NOTRDY]) begin
              fetch_go = 1'b1;
              state_d = dcs_pkg::ST_FETCH;
            end
          end
          default: begin
            if (!pend[`DCS_F_ABORT]) begin
              adv = 1'b1;
              state_d = dcs_pkg::ST_IDLE;
            end
          end
        endcase
      end
      default: state_d = dcs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dcs_pkg::ST_IDLE;
      halt_q <= dcs_pkg::HALT_ERROR;
    end else begin
      state_q <= state_d;
      halt_q <= halt_d;
    end
  end

  // Position and count survive an error halt so the retry resumes in place
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_q <= 10'h000;
      bytes_remaining_q <= 15'h0000;
      desc_q <= '0;
      loaded_q <= 1'b0;
    end else if (adv) begin
      index_q <= 10'h000;
      loaded_q <= 1'b0;
    end else if (state_q == dcs_pkg::ST_FETCH && state_d == dcs_pkg::ST_LOAD_DST) begin
      desc_q <= desc_in;
      loaded_q <= 1'b1;
      if (!loaded_q) begin
        bytes_remaining_q <= desc_in.bytes_remaining;
        index_q <= 10'h000;
      end
    end else if (count) begin
      index_q <= index_q + op_bytes[9:0];
      bytes_remaining_q <= (bytes_remaining_q > op_bytes) ? bytes_remaining_q - op_bytes : 15'h0000;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      desc_req <= 1'b0;
      xfer_req <= 1'b0;
      xfer_second <= 1'b0;
      xfer_size <= `DCS_SIZE_32;
      wb_req <= 1'b0;
      wb_len <= 15'h0000;
      desc_next <= 1'b0;
      irq <= 1'b0;
    end else begin
      desc_req <= fetch_go | (desc_req & ~desc_ack);
      xfer_req <= op_go | op2_go | (xfer_req & ~xfer_ack);
      if (op_go || op2_go) begin
        xfer_second <= op2_go;
        xfer_size <= eff_size;
      end
      wb_req <= wb_go | (wb_req & ~wb_ack);
      if (wb_go) begin
        wb_len <= close_periph ? {5'h00, index_q} : bytes_remaining_q;
      end
      desc_next <= adv;
      irq <= |(pend & en_q);
    end
  end

  property p_irq_level;
    @(posedge clk) disable iff (!rst_n)
    (|(pend & en_q)) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq low with enabled flag");

  property p_irq_hold;
    @(posedge clk) disable iff (!rst_n)
    !(|(pend & en_q)) |=> !irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq high with no flag");

  property p_err_halts;
    @(posedge clk) disable iff (!rst_n)
    $rose(pend[`DCS_F_ERROR]) |-> state_q == dcs_pkg::ST_HALT && !desc_next;
  endproperty
  a_err_halts: assert property (p_err_halts) else $error("no halt on error");

  property p_err_resume;
    @(posedge clk) disable iff (!rst_n)
    $fell(pend[`DCS_F_ERROR]) && halt_q == dcs_pkg::HALT_ERROR && state_q == dcs_pkg::ST_HALT
    |=> state_q == dcs_pkg::ST_FETCH && index_q == $past(index_q) && desc_req;
  endproperty
  a_err_resume: assert property (p_err_resume) else $error("error retry lost position");

  property p_nr_retry;
    @(posedge clk) disable iff (!rst_n)
    $rose(pend[`DCS_F_NOTRDY]) |-> state_q == dcs_pkg::ST_HALT ##1
    (!desc_next throughout pend[`DCS_F_NOTRDY][*2]);
  endproperty
  a_nr_retry: assert property (p_nr_retry) else $error("advanced on not ready");

  property p_abort_adv;
    @(posedge clk) disable iff (!rst_n)
    state_q == dcs_pkg::ST_HALT && halt_q == dcs_pkg::HALT_ABORT && !pend[`DCS_F_ABORT]
    |=> desc_next ##1 !desc_next;
  endproperty
  a_abort_adv: assert property (p_abort_adv) else $error("abort did not advance");

  property p_abort_set;
    @(posedge clk) disable iff (!rst_n)
    state_q == dcs_pkg::ST_IDLE && ctrl_q.enable && ctrl_q.abort_request
    |=> pend[`DCS_F_ABORT] && state_q == dcs_pkg::ST_HALT;
  endproperty
  a_abort_set: assert property (p_abort_set) else $error("abort not flagged");

  property p_size_word;
    @(posedge clk) disable iff (!rst_n)
    $rose(xfer_req) && ctrl_q.mode == `DCS_MODE_INT |-> xfer_size == `DCS_SIZE_32;
  endproperty
  a_size_word: assert property (p_size_word) else $error("size used in internal mode");

  property p_w1c;
    @(posedge clk) disable iff (!rst_n)
    wr_stat && wdata[`DCS_STAT_PEND_LO + `DCS_F_NOTRDY] && !ev[`DCS_F_NOTRDY]
    |=> !pend[`DCS_F_NOTRDY];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

endmodule

// ===== dcs_partner.sv
// Behavioural model of the memory and peripherals behind the channel
`timescale 1ns/1ns
module dcs_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic desc_req,
  input wire logic xfer_req,
  input wire logic wb_req,
  input wire logic hold_desc,
  input wire logic bad_ptr,
  input wire logic bad_data,
  input wire logic [1:0] delay,
  input wire dcs_pkg::dcs_desc_t desc_cfg,
  output logic desc_ack,
  output logic desc_bad_ptr,
  output dcs_pkg::dcs_desc_t desc_in,
  output logic xfer_ack,
  output logic xfer_err,
  output logic wb_ack
);
  logic [1:0] wait_q;
  logic busy;
  logic any_req;
  assign busy = desc_ack | xfer_ack | wb_ack;
  assign any_req = desc_req | xfer_req | wb_req;
  // One answer at a time after a programmable stall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 2'h0;
      desc_ack <= 1'b0;
      desc_bad_ptr <= 1'b0;
      desc_in <= '0;
      xfer_ack <= 1'b0;
      xfer_err <= 1'b0;
      wb_ack <= 1'b0;
    end else begin
      desc_ack <= 1'b0;
      desc_bad_ptr <= 1'b0;
      xfer_ack <= 1'b0;
      xfer_err <= 1'b0;
      wb_ack <= 1'b0;
      // Descriptor lines inverted every cycle without a descriptor answer, so stale data does not sit steady
      desc_in <= ~desc_in;
      if (busy || !any_req || (desc_req && hold_desc)) begin
        wait_q <= 2'h0;
      end else if (wait_q != delay) begin
        wait_q <= wait_q + 2'h1;
      end else begin
        wait_q <= 2'h0;
        desc_ack <= desc_req;
        desc_bad_ptr <= desc_req & bad_ptr;
        if (desc_req) begin
          desc_in <= desc_cfg;
        end
        xfer_ack <= xfer_req;
        xfer_err <= xfer_req & bad_data;
        wb_ack <= wb_req;
      end
    end
  end
endmodule

// ===== testbench.sv
// Self-checking bench for the channel status/control block
`timescale 1ns/1ns
`include "dcs_defines.svh"
module testbench;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, irq, hold, bad_ptr, bad_data, tend_n;
  logic [1:0] htrans, xfer_size, delay, lsize;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic desc_req, desc_ack, desc_bad_ptr, desc_next, xfer_req, xfer_second, xfer_ack;
  logic xfer_err, wb_req, wb_ack, saw2;
  logic [14:0] wb_len, wlen;
  dcs_pkg::dcs_desc_t desc_in, cfg;
  int errors, check_count, nacks, dn, cyc, n0, d0;

  dcs_channel dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .desc_req(desc_req),
    .desc_ack(desc_ack), .desc_bad_ptr(desc_bad_ptr), .desc_in(desc_in),
    .desc_next(desc_next), .xfer_req(xfer_req), .xfer_second(xfer_second),
    .xfer_size(xfer_size), .xfer_ack(xfer_ack), .xfer_err(xfer_err),
    .transfer_end_n(tend_n), .wb_req(wb_req), .wb_len(wb_len), .wb_ack(wb_ack), .irq(irq));

  dcs_partner far_u (.clk(clk), .rst_n(rst_n), .desc_req(desc_req), .xfer_req(xfer_req),
    .wb_req(wb_req), .hold_desc(hold), .bad_ptr(bad_ptr), .bad_data(bad_data),
    .delay(delay), .desc_cfg(cfg), .desc_ack(desc_ack), .desc_bad_ptr(desc_bad_ptr),
    .desc_in(desc_in), .xfer_ack(xfer_ack), .xfer_err(xfer_err), .wb_ack(wb_ack));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One single word transfer; a hang is cut by the cycle ceiling
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic wait_stat(input int b);
    v = 32'h0;
    while (v[b] !== 1'b1) rd(`DCS_ADDR_STAT);
  endtask

  // Lets exactly one descriptor fetch through
  task automatic release_one();
    while (desc_req !== 1'b1) @(posedge clk);
    hold <= 1'b0;
    do @(posedge clk); while (desc_ack !== 1'b1);
    hold <= 1'b1;
  endtask

  function automatic logic [31:0] cw(input logic ab, input logic [1:0] m, input logic [1:0] s);
    return {1'b1, ab, 10'h0, m, s, 16'h0};
  endfunction

  function automatic logic [31:0] sw(input logic [3:0] p, input logic [3:0] e);
    return {p, 4'h0, e, 20'h0};
  endfunction

  always @(posedge clk) begin
    cyc++;
    if (xfer_req && xfer_ack && !xfer_err) begin
      nacks++;
      lsize = xfer_size;
      if (xfer_second) saw2 = 1'b1;
    end
    if (desc_next) dn++;
    if (wb_req && wb_ack) wlen = wb_len;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    errors = 0;
    check_count = 0;
    nacks = 0;
    dn = 0;
    cyc = 0;
    saw2 = 1'b0;
    lsize = 2'h3;
    wlen = 15'h7fff;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hold = 1'b1;
    bad_ptr = 1'b0;
    bad_data = 1'b0;
    delay = 2'h0;
    tend_n = 1'b1;
    cfg = {1'b1, 4'h0, 15'h4};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`DCS_ADDR_CTRL);
    chk(v, `DCS_RST_CTRL);
    rd(`DCS_ADDR_STAT);
    chk(v, 32'h0);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08);
    chk(v, 32'h0);
    $display("Test reset and unmapped done");
    wr(`DCS_ADDR_CTRL, cw(1'b1, `DCS_MODE_M2M, `DCS_SIZE_32));
    wait_stat(28);
    chk(v[31:28], 4'h1);
    chk(dn, 0);
    chk(irq, 1'b0);
    wr(`DCS_ADDR_STAT, sw(4'h1, 4'h0));
    wait_stat(28);
    chk(dn, 1);
    wr(`DCS_ADDR_CTRL, 32'h0);
    wr(`DCS_ADDR_STAT, sw(4'h1, 4'h0));
    repeat (4) @(posedge clk);
    rd(`DCS_ADDR_STAT);
    chk(v[31:28], 4'h0);
    chk(dn, 2);
    $display("Test abort done");
    wr(`DCS_ADDR_STAT, sw(4'h0, 4'hf));
    wr(`DCS_ADDR_CTRL, cw(1'b0, `DCS_MODE_M2M, `DCS_SIZE_8));
    d0 = dn;
    release_one();
    wait_stat(31);
    chk(v[31:28], 4'h8);
    chk(irq, 1'b1);
    chk(wlen, 15'h0);
    chk(dn, d0 + 1);
    chk(lsize, `DCS_SIZE_8);
    chk(saw2, 1'b1);
    wr(`DCS_ADDR_STAT, sw(4'h0, 4'hf));
    rd(`DCS_ADDR_STAT);
    chk(v[31:28], 4'h8);
    wr(`DCS_ADDR_STAT, sw(4'h8, 4'hf));
    rd(`DCS_ADDR_STAT);
    chk(v[31:28], 4'h0);
    chk(irq, 1'b0);
    rd(`DCS_ADDR_CTRL);
    chk(v[15:10], `DCS_CODE_LOAD_SRC);
    $display("Test normal done");
    cfg <= {1'b0, 4'h0, 15'h8};
    wr(`DCS_ADDR_CTRL, cw(1'b0, `DCS_MODE_INT, `DCS_SIZE_8));
    d0 = dn;
    release_one();
    wait_stat(29);
    chk(v[31:28], 4'h2);
    chk(dn, d0);
    rd(`DCS_ADDR_CTRL);
    chk(v[15:10], `DCS_CODE_IDLE);
    cfg <= {1'b1, 4'hd, 15'h8};
    wr(`DCS_ADDR_STAT, sw(4'h2, 4'h7));
    release_one();
    wait_stat(31);
    chk(v[31:28], 4'h8);
    chk(irq, 1'b0);
    chk(lsize, `DCS_SIZE_32);
    chk(dn, d0 + 1);
    wr(`DCS_ADDR_STAT, sw(4'h8, 4'h7));
    $display("Test not ready done");
    bad_data <= 1'b1;
    d0 = dn;
    release_one();
    wait_stat(30);
    bad_data <= 1'b0;
    chk(v[31:28], 4'h4);
    chk(v[19:0], {4'hd, 1'b0, 15'h8});
    chk(irq, 1'b1);
    chk(dn, d0);
    n0 = nacks;
    wr(`DCS_ADDR_STAT, sw(4'h4, 4'h7));
    release_one();
    wait_stat(31);
    chk(nacks - n0, 2);
    chk(dn, d0 + 1);
    // Normal-done enable on: the next descriptors carry no done-irq bit
    wr(`DCS_ADDR_STAT, sw(4'h8, 4'hf));
    $display("Test error done");
    cfg <= {1'b1, 4'h0, 15'd100};
    delay <= 2'h2;
    wr(`DCS_ADDR_CTRL, cw(1'b0, `DCS_MODE_EXT, `DCS_SIZE_8));
    n0 = nacks;
    release_one();
    while (nacks - n0 < 3) @(posedge clk);
    tend_n <= 1'b0;
    wait_stat(31);
    tend_n <= 1'b1;
    chk(wlen, nacks - n0);
    chk(lsize, `DCS_SIZE_8);
    $display("Test peripheral end done");
    // Abort raised while a descriptor is being fetched
    wr(`DCS_ADDR_STAT, sw(4'h8, 4'hf));
    cfg <= {1'b1, 4'h0, 15'h2};
    wr(`DCS_ADDR_CTRL, cw(1'b1, `DCS_MODE_EXT, `DCS_SIZE_8));
    d0 = dn;
    release_one();
    wait_stat(28);
    chk(v[31:28], 4'h1);
    chk(dn, d0);
    wr(`DCS_ADDR_CTRL, cw(1'b0, `DCS_MODE_EXT, `DCS_SIZE_8));
    wr(`DCS_ADDR_STAT, sw(4'h1, 4'hf));
    repeat (4) @(posedge clk);
    chk(dn, d0 + 1);
    $display("Test abort mid-chain done");
    // Bad descriptor pointer, then a clean retry
    bad_ptr <= 1'b1;
    d0 = dn;
    release_one();
    wait_stat(30);
    bad_ptr <= 1'b0;
    chk(v[31:28], 4'h4);
    chk(dn, d0);
    wr(`DCS_ADDR_STAT, sw(4'h4, 4'hf));
    release_one();
    wait_stat(31);
    chk(wlen, 15'h0);
    chk(dn, d0 + 1);
    $display("Test bad pointer done");
    close_out();
  end
endmodule
